//--- hw/tx_drive_pkg.sv
package tx_drive_pkg;

    localparam int NUM_SERDES = 12;
    localparam int NUM_LANES  = 4;
    localparam int ADDR_W     = 8;
    localparam int DATA_W     = 32;
    localparam int STRB_W     = DATA_W / 8;

    // Register map: each SerDes owns two words of a slot
    localparam logic [ADDR_W-1:0] SLOT_STRIDE    = 8'h08;
    localparam logic [ADDR_W-1:0] DRIVE_OFFSET   = 8'h00;
    localparam logic [ADDR_W-1:0] CTRL_OFFSET    = 8'h04;
    localparam int                SLOT_LSB       = 3;
    localparam int                SLOT_MSB       = 6;
    localparam int                WORD_BIT       = 2;
    localparam int                OUT_OF_MAP_BIT = 7;

    // Drive register field positions
    localparam int AMP_G1_LSB       = 0;
    localparam int FINE_G1_LSB      = 5;
    localparam int AMP_G2_LO_LSB    = 8;
    localparam int FINE_G2_LO_LSB   = 13;
    localparam int AMP_G2_HI_LSB    = 16;
    localparam int DRIVE_FIELDS_W   = 21;

    // Control register field positions
    localparam int LANE_PICK_LSB    = 0;
    localparam int DEEMPH_SEL_BIT   = 4;
    localparam int LOW_SWING_BIT    = 5;
    localparam int CTRL_W           = 6;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Stored per lane, packed in the same order as the register bits
    typedef struct packed {
        logic [4:0] amp_full_g2_high_deemph;
        logic [2:0] fine_deemph_g2_low_deemph;
        logic [4:0] amp_full_g2_low_deemph;
        logic [2:0] fine_deemph_full_g1;
        logic [4:0] amp_full_g1;
    } lane_fields_t;

    localparam lane_fields_t FIELDS_RST = '{
        amp_full_g2_high_deemph:   5'h13,
        fine_deemph_g2_low_deemph: 3'h4,
        amp_full_g2_low_deemph:    5'h17,
        fine_deemph_full_g1:       3'h4,
        amp_full_g1:               5'h11
    };

    // deemph_select: 1 picks -3.5dB, 0 picks -6.0dB
    typedef struct packed {
        logic       low_swing_enable;
        logic       deemph_select;
        logic [3:0] lane_pick;
    } serdes_ctrl_t;

    localparam serdes_ctrl_t CTRL_RST = '{
        low_swing_enable: 1'h0,
        deemph_select:    1'h1,
        lane_pick:        4'hf
    };

    // Setting handed to one lane transmitter
    typedef struct packed {
        logic [4:0] amp;
        logic [2:0] fine_deemph;
        logic       deemph_en;
    } lane_drive_t;

    localparam lane_drive_t DRIVE_RST = '{
        amp:         5'h11,
        fine_deemph: 3'h4,
        deemph_en:   1'h1
    };

endpackage

//--- hw/lane_drive_pick.sv
`timescale 1ns/1ps
`default_nettype none

module lane_drive_pick
    import tx_drive_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         gen2,
    input  wire logic         deemph_select,
    input  wire logic         low_swing_enable,
    input  wire lane_fields_t fields,
    output lane_drive_t       drive
);

    lane_drive_t drive_ff;
    lane_drive_t nxt_drive;

    always_comb begin
        nxt_drive = drive_ff;
        if (!gen2) begin
            nxt_drive.amp         = fields.amp_full_g1;
            nxt_drive.fine_deemph = fields.fine_deemph_full_g1;
        end else if (deemph_select) begin
            nxt_drive.amp         = fields.amp_full_g2_low_deemph;
            nxt_drive.fine_deemph = fields.fine_deemph_g2_low_deemph;
        end else begin
            nxt_drive.amp         = fields.amp_full_g2_high_deemph;
            nxt_drive.fine_deemph = 3'h0;
        end
        nxt_drive.deemph_en = 1'b1; // R12
        // Low swing turns de-emphasis off, fine settings unused
        if (low_swing_enable) begin // R11
            nxt_drive.fine_deemph = 3'h0; // R7
            nxt_drive.deemph_en   = 1'b0; // R7
        end
        if (!ce) begin
            nxt_drive = drive_ff;
        end
        if (!rst_n) begin
            nxt_drive = DRIVE_RST;
        end
    end

    always_ff @(posedge clk) begin
        drive_ff <= nxt_drive;
    end

    assign drive = drive_ff;

    property p_low_swing_no_deemph;
        @(posedge clk) disable iff (!rst_n)
        ($past(low_swing_enable) && $past(ce) && $past(rst_n)) |->
            (!drive_ff.deemph_en && drive_ff.fine_deemph == 3'h0);
    endproperty
    a_low_swing_no_deemph: assert property (p_low_swing_no_deemph) // R7
        else $error("de-emphasis active in low swing");

    property p_full_swing_deemph_on;
        @(posedge clk) disable iff (!rst_n)
        (ce && !low_swing_enable) |=> drive_ff.deemph_en;
    endproperty
    a_full_swing_deemph_on: assert property (p_full_swing_deemph_on) // R11
        else $error("de-emphasis off in full swing");

    property p_route_field;
        @(posedge clk) disable iff (!rst_n)
        (ce && !low_swing_enable && !gen2) |=>
            (drive_ff.amp == $past(fields.amp_full_g1)
             && drive_ff.fine_deemph == $past(fields.fine_deemph_full_g1));
    endproperty
    a_route_field: assert property (p_route_field) // R12
        else $error("gen1 lane setting not routed");

    property p_route_g2_low;
        @(posedge clk) disable iff (!rst_n)
        (ce && gen2 && deemph_select) |=>
            drive_ff.amp == $past(fields.amp_full_g2_low_deemph);
    endproperty
    a_route_g2_low: assert property (p_route_g2_low) // R12
        else $error("gen2 -3.5dB amplitude not routed");

endmodule

`default_nettype wire

//--- hw/serdes_tx_lane_drive_regs.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// How it works
// [R1] There is one drive register per SerDes, twelve of them numbered 0 to 11.
// [R2] Bits 4:0 hold the gen1 full-swing amplitude, read-write, reset 0x11.
// [R3] Bits 7:5 hold the gen1 full-swing fine de-emphasis, read-write, reset 0x4.
// [R4] Bits 12:8 hold the gen2 full-swing amplitude for -3.5dB, read-write, reset 0x17.
// [R5] Bits 15:13 hold the gen2 fine de-emphasis for -3.5dB, read-write, reset 0x4.
// [R6] Bits 20:16 hold the gen2 full-swing amplitude for -6.0dB, read-write, reset 0x13.
// [R7] In low-swing mode both fine de-emphasis settings are ignored.
// [R8] A write updates only the lanes chosen by the 4-bit lane pick field.
// [R9] Each lane copy survives ordinary resets and clears only on the sticky reset.
// [R10] Software should set gen1 de-emphasis near -3.5dB; hardware does not enforce it.
// [R11] A port is in low swing when its low-swing enable bit is 1.
// [R12] Every lane stores its own fields and gets the one for its rate, select and swing.
module serdes_tx_lane_drive_regs
    import tx_drive_pkg::*;
(
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    sticky_rst_n,
    input  wire logic                    ce,
    input  wire logic [NUM_SERDES-1:0]   link_gen2,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [ADDR_W-1:0]       s_axi_awaddr,
    input  wire logic [2:0]              s_axi_awprot,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    input  wire logic [DATA_W-1:0]       s_axi_wdata,
    input  wire logic [STRB_W-1:0]       s_axi_wstrb,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    output logic [1:0]                   s_axi_bresp,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    input  wire logic [ADDR_W-1:0]       s_axi_araddr,
    input  wire logic [2:0]              s_axi_arprot,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    output logic [DATA_W-1:0]            s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output lane_drive_t [NUM_SERDES*NUM_LANES-1:0] tx_drive
);

    typedef struct packed {
        lane_fields_t [NUM_SERDES-1:0][NUM_LANES-1:0] fields;
        serdes_ctrl_t [NUM_SERDES-1:0]                ctrl;
        logic                                         aw_held;
        logic [ADDR_W-1:0]                            awaddr;
        logic                                         w_held;
        logic [DATA_W-1:0]                            wdata;
        logic [STRB_W-1:0]                            wstrb;
        logic                                         bvalid;
        logic [1:0]                                   bresp;
        logic                                         rvalid;
        logic [DATA_W-1:0]                            rdata;
        logic [1:0]                                   rresp;
    } regs_t;

    regs_t st_ff;
    regs_t nxt_st;

    logic [DATA_W-1:0] bit_mask;

    // Slot decode: returns 1 when the address hits a register
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        logic hit;
        hit = 1'b0;
        if (a[OUT_OF_MAP_BIT]) begin
            hit = 1'b0;
        end else if (32'(a[SLOT_MSB:SLOT_LSB]) >= NUM_SERDES) begin
            hit = 1'b0; // R1
        end else if (a[1:0] != 2'h0) begin
            hit = 1'b0;
        end else begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Lowest picked lane is the one shown on reads
    function automatic logic [1:0] shown_lane(input logic [3:0] pick);
        logic [1:0] l;
        l = 2'h0;
        for (int i = NUM_LANES - 1; i >= 0; i--) begin
            if (pick[i]) begin
                l = 2'(i);
            end
        end
        return l;
    endfunction

    function automatic logic [DATA_W-1:0] read_word(input regs_t s,
                                                    input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        logic [3:0]        slot;
        d    = '0;
        slot = a[SLOT_MSB:SLOT_LSB];
        if (a[WORD_BIT]) begin
            d[CTRL_W-1:0] = s.ctrl[slot];
        end else begin
            d[DRIVE_FIELDS_W-1:0] = s.fields[slot][shown_lane(s.ctrl[slot].lane_pick)];
        end
        return d;
    endfunction

    // Byte strobes widened to a bit mask
    generate
        for (genvar b = 0; b < STRB_W; b++) begin : g_mask
            assign bit_mask[b*8 +: 8] = {8{st_ff.wstrb[b]}};
        end
    endgenerate

    always_comb begin
        logic [3:0]         slot;
        logic [DATA_W-1:0]  old_word;
        logic [DATA_W-1:0]  new_word;
        slot     = st_ff.awaddr[SLOT_MSB:SLOT_LSB];
        old_word = '0;
        new_word = '0;
        nxt_st   = st_ff;

        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_st.aw_held = 1'b1;
            nxt_st.awaddr  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_st.w_held = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
        end

        // Both halves of a write present: apply it and answer
        if (st_ff.aw_held && st_ff.w_held && !st_ff.bvalid) begin
            nxt_st.aw_held = 1'b0;
            nxt_st.w_held  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = RESP_DECERR;
            if (addr_hit(st_ff.awaddr)) begin
                nxt_st.bresp = RESP_OKAY;
                if (st_ff.awaddr[WORD_BIT]) begin
                    old_word[CTRL_W-1:0] = st_ff.ctrl[slot];
                    new_word = (old_word & ~bit_mask) | (st_ff.wdata & bit_mask);
                    nxt_st.ctrl[slot] = new_word[CTRL_W-1:0];
                end else begin
                    for (int l = 0; l < NUM_LANES; l++) begin
                        if (st_ff.ctrl[slot].lane_pick[l]) begin // R8
                            old_word = '0;
                            old_word[DRIVE_FIELDS_W-1:0] = st_ff.fields[slot][l];
                            new_word = (old_word & ~bit_mask)
                                     | (st_ff.wdata & bit_mask);
                            // R2 R3 R4 R5 R6 field layout follows the packing
                            nxt_st.fields[slot][l] = new_word[DRIVE_FIELDS_W-1:0];
                        end
                    end
                end
            end
        end

        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = '0;
            nxt_st.rresp  = RESP_DECERR; // R1
            if (addr_hit(s_axi_araddr)) begin
                nxt_st.rdata = read_word(st_ff, s_axi_araddr);
                nxt_st.rresp = RESP_OKAY;
            end
        end

        if (!ce) begin
            nxt_st = st_ff;
        end
        // Ordinary reset leaves the lane settings alone
        if (!rst_n) begin
            nxt_st.fields  = st_ff.fields; // R9
            nxt_st.ctrl    = {NUM_SERDES{CTRL_RST}};
            nxt_st.aw_held = 1'b0;
            nxt_st.awaddr  = '0;
            nxt_st.w_held  = 1'b0;
            nxt_st.wdata   = '0;
            nxt_st.wstrb   = '0;
            nxt_st.bvalid  = 1'b0;
            nxt_st.bresp   = RESP_OKAY;
            nxt_st.rvalid  = 1'b0;
            nxt_st.rdata   = '0;
            nxt_st.rresp   = RESP_OKAY;
        end
        if (!sticky_rst_n) begin
            nxt_st.fields = {(NUM_SERDES*NUM_LANES){FIELDS_RST}}; // R9
        end
    end

    always_ff @(posedge clk) begin
        st_ff <= nxt_st;
    end

    assign s_axi_awready = ce && rst_n && !st_ff.aw_held && !st_ff.bvalid;
    assign s_axi_wready  = ce && rst_n && !st_ff.w_held && !st_ff.bvalid;
    assign s_axi_arready = ce && rst_n && !st_ff.rvalid;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;

    generate
        for (genvar s = 0; s < NUM_SERDES; s++) begin : g_serdes
            for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
                lane_drive_pick u_pick (
                    .clk              (clk),
                    .rst_n            (rst_n),
                    .ce               (ce),
                    .gen2             (link_gen2[s]),
                    .deemph_select    (st_ff.ctrl[s].deemph_select),
                    .low_swing_enable (st_ff.ctrl[s].low_swing_enable),
                    .fields           (st_ff.fields[s][l]),
                    .drive            (tx_drive[s*NUM_LANES+l])
                );
            end
        end
    endgenerate

    property p_unmapped_decerr;
        @(posedge clk) disable iff (!rst_n)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr[SLOT_MSB:SLOT_LSB] == 4'hc
         && !s_axi_araddr[OUT_OF_MAP_BIT])
        |=> (s_axi_rvalid && s_axi_rresp == RESP_DECERR);
    endproperty
    a_unmapped_decerr: assert property (p_unmapped_decerr) // R1
        else $error("slot 12 not refused");

    property p_amp_g1_rst;
        @(posedge clk) disable iff (!rst_n)
        !sticky_rst_n |=> st_ff.fields[0][0].amp_full_g1 == 5'h11;
    endproperty
    a_amp_g1_rst: assert property (p_amp_g1_rst) // R2
        else $error("gen1 amplitude reset wrong");

    property p_fine_g1_rst;
        @(posedge clk) disable iff (!rst_n)
        !sticky_rst_n |=> st_ff.fields[11][3].fine_deemph_full_g1 == 3'h4;
    endproperty
    a_fine_g1_rst: assert property (p_fine_g1_rst) // R3
        else $error("gen1 fine de-emphasis reset wrong");

    property p_amp_g2_lo_rst;
        @(posedge clk) disable iff (!rst_n)
        !sticky_rst_n |=> st_ff.fields[5][1].amp_full_g2_low_deemph == 5'h17;
    endproperty
    a_amp_g2_lo_rst: assert property (p_amp_g2_lo_rst) // R4
        else $error("gen2 -3.5dB amplitude reset wrong");

    property p_fine_g2_lo_rst;
        @(posedge clk) disable iff (!rst_n)
        !sticky_rst_n |=> st_ff.fields[7][2].fine_deemph_g2_low_deemph == 3'h4;
    endproperty
    a_fine_g2_lo_rst: assert property (p_fine_g2_lo_rst) // R5
        else $error("gen2 fine de-emphasis reset wrong");

    property p_amp_g2_hi_rst;
        @(posedge clk) disable iff (!rst_n)
        !sticky_rst_n |=> st_ff.fields[3][0].amp_full_g2_high_deemph == 5'h13;
    endproperty
    a_amp_g2_hi_rst: assert property (p_amp_g2_hi_rst) // R6
        else $error("gen2 -6.0dB amplitude reset wrong");

    property p_unpicked_lane_kept;
        @(posedge clk) disable iff (!rst_n)
        (ce && sticky_rst_n && st_ff.aw_held && st_ff.w_held && !st_ff.bvalid
         && st_ff.awaddr == SLOT_STRIDE && !st_ff.ctrl[1].lane_pick[0])
        |=> $stable(st_ff.fields[1][0]);
    endproperty
    a_unpicked_lane_kept: assert property (p_unpicked_lane_kept) // R8
        else $error("lane outside pick was written");

    property p_sticky_kept;
        @(posedge clk)
        disable iff (!sticky_rst_n)
        (!rst_n) |=> $stable(st_ff.fields);
    endproperty
    a_sticky_kept: assert property (p_sticky_kept) // R9
        else $error("lane settings lost on ordinary reset");

    property p_write_answer;
        @(posedge clk) disable iff (!rst_n)
        (ce && st_ff.aw_held && st_ff.w_held && !st_ff.bvalid)
        |=> s_axi_bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer) // R8
        else $error("write not answered next cycle");

endmodule

`default_nettype wire

//--- sim/serdes_tx_lane_drive_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin miscompares++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module serdes_tx_lane_drive_regs_tb
    import tx_drive_pkg::*;
;
    logic                                  clk = 1'b0;
    logic                                  rst_n = 1'b0;
    logic                                  sticky_rst_n = 1'b0;
    logic                                  ce = 1'b1;
    logic [NUM_SERDES-1:0]                 link_gen2 = '0;
    logic                                  s_axi_awvalid = 1'b0;
    logic                                  s_axi_awready;
    logic [ADDR_W-1:0]                     s_axi_awaddr = '0;
    logic                                  s_axi_wvalid = 1'b0;
    logic                                  s_axi_wready;
    logic [DATA_W-1:0]                     s_axi_wdata = '0;
    logic [STRB_W-1:0]                     s_axi_wstrb = '0;
    logic                                  s_axi_bvalid;
    logic                                  s_axi_bready = 1'b0;
    logic [1:0]                            s_axi_bresp;
    logic                                  s_axi_arvalid = 1'b0;
    logic                                  s_axi_arready;
    logic [ADDR_W-1:0]                     s_axi_araddr = '0;
    logic                                  s_axi_rvalid;
    logic                                  s_axi_rready = 1'b0;
    logic [DATA_W-1:0]                     s_axi_rdata;
    logic [1:0]                            s_axi_rresp;
    lane_drive_t [NUM_SERDES*NUM_LANES-1:0] tx_drive;
    int                                    miscompares = 0;
    int                                    samples_checked = 0;

    typedef struct {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [3:0]  strb;
        logic [31:0] rdata;
        logic [1:0]  resp;
    } row_t;

    typedef struct {
        logic       gen2;
        logic       sel;
        logic       low;
        logic [4:0] amp;
        logic [2:0] fine;
        logic       en;
    } mode_t;

    // Rows run in order; some rows depend on earlier ones
    row_t rows [11] = '{
        '{8'h00, 32'hffffffff, 4'hf, 32'h001fffff, RESP_OKAY},
        '{8'h58, 32'h00000000, 4'hf, 32'h00000000, RESP_OKAY},
        '{8'h28, 32'h00aa5555, 4'hf, 32'h000a5555, RESP_OKAY},
        '{8'h18, 32'h00000000, 4'h1, 32'h00139700, RESP_OKAY},
        '{8'h20, 32'hffffffff, 4'h4, 32'h001f9791, RESP_OKAY},
        '{8'h34, 32'hffffffff, 4'hf, 32'h0000003f, RESP_OKAY},
        '{8'h3c, 32'h00000010, 4'hf, 32'h00000010, RESP_OKAY},
        '{8'h38, 32'h00000000, 4'hf, 32'h00139791, RESP_OKAY},
        '{8'h60, 32'h12345678, 4'hf, 32'h00000000, RESP_DECERR},
        '{8'hfc, 32'h12345678, 4'hf, 32'h00000000, RESP_DECERR},
        '{8'h02, 32'h12345678, 4'hf, 32'h00000000, RESP_DECERR}
    };

    // Field values in serdes 2 are 0x01, 0x2, 0x03, 0x5, 0x07
    mode_t modes [5] = '{
        '{1'b0, 1'b1, 1'b0, 5'h01, 3'h2, 1'b1},
        '{1'b1, 1'b1, 1'b0, 5'h03, 3'h5, 1'b1},
        '{1'b1, 1'b0, 1'b0, 5'h07, 3'h0, 1'b1},
        '{1'b1, 1'b1, 1'b1, 5'h03, 3'h0, 1'b0},
        '{1'b0, 1'b1, 1'b1, 5'h01, 3'h0, 1'b0}
    };

    serdes_tx_lane_drive_regs uut (
        .clk           (clk),
        .rst_n         (rst_n),
        .sticky_rst_n  (sticky_rst_n),
        .ce            (ce),
        .link_gen2     (link_gen2),
        .s_axi_awvalid (s_axi_awvalid),
        .s_axi_awready (s_axi_awready),
        .s_axi_awaddr  (s_axi_awaddr),
        .s_axi_awprot  (3'h0),
        .s_axi_wvalid  (s_axi_wvalid),
        .s_axi_wready  (s_axi_wready),
        .s_axi_wdata   (s_axi_wdata),
        .s_axi_wstrb   (s_axi_wstrb),
        .s_axi_bvalid  (s_axi_bvalid),
        .s_axi_bready  (s_axi_bready),
        .s_axi_bresp   (s_axi_bresp),
        .s_axi_arvalid (s_axi_arvalid),
        .s_axi_arready (s_axi_arready),
        .s_axi_araddr  (s_axi_araddr),
        .s_axi_arprot  (3'h0),
        .s_axi_rvalid  (s_axi_rvalid),
        .s_axi_rready  (s_axi_rready),
        .s_axi_rdata   (s_axi_rdata),
        .s_axi_rresp   (s_axi_rresp),
        .tx_drive      (tx_drive)
    );

    always #2.5 clk = ~clk;

    task automatic report_and_stop();
        if (miscompares == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Entered just after a rising edge; leaves one idle edge behind it
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        s_axi_awvalid <= 1'b1;
        s_axi_awaddr  <= a;
        s_axi_wvalid  <= 1'b1;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        s_axi_arvalid <= 1'b1;
        s_axi_araddr  <= a;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        `CHK(s_axi_rdata, ed)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask

    task automatic check_lane(input int i, input logic [4:0] amp, input logic [2:0] fine,
                              input logic en);
        lane_drive_t exp_d;
        exp_d = '{amp: amp, fine_deemph: fine, deemph_en: en};
        `CHK(tx_drive[i], exp_d)
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        report_and_stop();
    end

    initial begin
        repeat (2) @(posedge clk);
        rst_n        <= 1'b1;
        sticky_rst_n <= 1'b1;
        @(posedge clk);
        // Defaults of every SerDes and every lane
        for (int s = 0; s < NUM_SERDES; s++) begin
            axi_rd(8'(s * 8), 32'h00139791, RESP_OKAY);
            axi_rd(8'(s * 8 + 4), 32'h0000001f, RESP_OKAY);
        end
        for (int i = 0; i < NUM_SERDES * NUM_LANES; i++) check_lane(i, 5'h11, 3'h4, 1'b1);
        for (int r = 0; r < 11; r++) begin
            axi_wr(rows[r].addr, rows[r].wdata, rows[r].strb, rows[r].resp);
            axi_rd(rows[r].addr, rows[r].rdata, rows[r].resp);
        end
        for (int i = 0; i < NUM_LANES; i++) check_lane(i, 5'h1f, 3'h7, 1'b1);
        // Serdes 6 is in low swing, gen1
        for (int i = 24; i < 28; i++) check_lane(i, 5'h11, 3'h0, 1'b0);
        // Only lane 2 of serdes 1 picked
        axi_wr(8'h0c, 32'h00000014, 4'hf, RESP_OKAY);
        axi_wr(8'h08, 32'h00000000, 4'hf, RESP_OKAY);
        axi_rd(8'h08, 32'h00000000, RESP_OKAY);
        repeat (2) @(posedge clk);
        for (int i = 4; i < 8; i++) begin
            if (i == 6) check_lane(i, 5'h00, 3'h0, 1'b1);
            else check_lane(i, 5'h11, 3'h4, 1'b1);
        end
        axi_wr(8'h0c, 32'h00000011, 4'hf, RESP_OKAY);
        axi_rd(8'h08, 32'h00139791, RESP_OKAY);
        // Rate, select and swing routing on serdes 2
        axi_wr(8'h10, 32'h0007a341, 4'hf, RESP_OKAY);
        for (int m = 0; m < 5; m++) begin
            link_gen2[2] <= modes[m].gen2;
            axi_wr(8'h14, {26'h0, modes[m].low, modes[m].sel, 4'hf}, 4'hf, RESP_OKAY);
            repeat (2) @(posedge clk);
            for (int i = 8; i < 12; i++)
                check_lane(i, modes[m].amp, modes[m].fine, modes[m].en);
        end
        // Clock enable low freezes lanes and drops readies
        ce           <= 1'b0;
        link_gen2[2] <= 1'b1;
        repeat (2) @(posedge clk);
        `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0)
        check_lane(8, 5'h01, 3'h0, 1'b0);
        ce           <= 1'b1;
        link_gen2[2] <= 1'b0;
        // Ordinary reset keeps lane settings
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'h0)
        rst_n <= 1'b1;
        @(posedge clk);
        axi_rd(8'h10, 32'h0007a341, RESP_OKAY);
        axi_rd(8'h14, 32'h0000001f, RESP_OKAY);
        check_lane(6, 5'h00, 3'h0, 1'b1);
        check_lane(8, 5'h01, 3'h2, 1'b1);
        // Sticky reset restores defaults
        sticky_rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        sticky_rst_n <= 1'b1;
        @(posedge clk);
        axi_rd(8'h10, 32'h00139791, RESP_OKAY);
        axi_rd(8'h00, 32'h00139791, RESP_OKAY);
        check_lane(6, 5'h11, 3'h4, 1'b1);
        report_and_stop();
    end
endmodule

`default_nettype wire
